// ===== rtl/flash_port_pkg.sv
// constants, carrier structs and state types for the isa flash pointer port
package flash_port_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int ISA_ADDR_W   = 20;   // sa[19:0]
   localparam int DATA_W       = 16;   // sd[15:0]
   localparam int PTR_LOW_W    = 16;   // word address bits 16..1
   localparam int PTR_HIGH_W   = 4;    // word address bits 20..17
   localparam int FLASH_ADDR_W = 20;   // word address bits 20..1, 2 Mbyte
   localparam int BOOT_ADDR_W  = 15;   // 32 Kbyte window
   localparam int BOOT_DATA_W  = 8;    // byte-wide boot path
   localparam int TIMER_W      = 6;    // write pulse counter

   // -----------------------------------------------------------------
   // i/o space map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [15:0] IO_BASE        = 16'h0300;
   localparam logic [15:0] IO_LAST        = 16'h0307;
   localparam logic [15:0] PTR_LOW_ADDR   = 16'h0300;  // flash_pointer_low, wo
   localparam logic [15:0] PTR_HIGH_ADDR  = 16'h0302;  // flash_pointer_high, wo
   localparam logic [15:0] WORD_PORT_ADDR = 16'h0304;  // flash_word_port, rw
   localparam int          IO_DEC_LSB     = 3;         // eight-byte block
   localparam int          IO_REG_LSB     = 1;         // word-wide registers

   // -----------------------------------------------------------------
   // memory space map
   // -----------------------------------------------------------------
   localparam logic [19:0] BOOT_BASE = 20'hC8000;
   localparam logic [19:0] BOOT_LAST = 20'hCFFFF;

   // -----------------------------------------------------------------
   // reset and fill values
   // -----------------------------------------------------------------
   localparam logic [15:0] PTR_LOW_RST  = 16'h0000;
   localparam logic [3:0]  PTR_HIGH_RST = 4'h0;
   localparam logic [15:0] READ_FILL    = 16'h0000;   // unreadable locations
   localparam logic [7:0]  BOOT_HI_FILL = 8'h00;      // upper lane on byte reads

   // -----------------------------------------------------------------
   // flash write strobe timing
   // -----------------------------------------------------------------
   localparam int SYS_CLK_MHZ  = 200;
   localparam int WE_LOW_NS    = 100;   // least write-enable low time
   localparam int WE_HOLD_NS   = 50;    // least data hold after we rises
   localparam int WE_LOW_CYC   = (WE_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int WE_HOLD_CYC  = (WE_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [TIMER_W-1:0] WE_LOW_LOAD  = TIMER_W'(WE_LOW_CYC);
   localparam logic [TIMER_W-1:0] WE_HOLD_LOAD = TIMER_W'(WE_HOLD_CYC);

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [ISA_ADDR_W-1:0] sa;       // system address
      logic                  aen;      // dma address enable, high = dma
      logic                  ior_n;    // i/o read strobe
      logic                  iow_n;    // i/o write strobe
      logic                  memr_n;   // memory read strobe
   } isa_ctl_t;

   typedef struct packed {
      logic [FLASH_ADDR_W-1:0] addr;   // word address a20..a1
      logic                    ce_n;
      logic                    oe_n;
      logic                    we_n;
   } flash_ctl_t;

   typedef enum logic [1:0] {W_IDLE, W_LOW, W_HOLD} wr_phase_t;

   typedef struct packed {
      isa_ctl_t               prev;       // last synced strobes
      logic                   wr_hit;     // write strobe open on our block
      logic [15:0]            waddr;      // address seen during write
      logic [DATA_W-1:0]      wdata;      // data seen during write
      logic [PTR_LOW_W-1:0]   ptr_low;
      logic [PTR_HIGH_W-1:0]  ptr_high;
      wr_phase_t              phase;
      flash_ctl_t             flash;
      logic [DATA_W-1:0]      dq_out;
      logic                   dq_oe;
      logic [DATA_W-1:0]      sd_out;
      logic                   sd_oe;
      logic                   iocs16_out;
      logic                   iocs16_oe;
      logic [BOOT_ADDR_W-1:0] boot_addr;
      logic                   boot_oe_n;
      logic                   vpp_en;
   } port_state_t;

endpackage : flash_port_pkg

// ===== rtl/pin_sync.sv
// two-flop synchroniser for a group of pins
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // raw and synced level
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] synced
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] meta;   // first stage, read only by the second
      logic [W-1:0] sync;   // second stage, safe to use
   } sync_state_t;

   sync_state_t st;        // registered copy
   sync_state_t next_st;   // next value

   // shift the pins one stage per clock
   always_comb begin
      next_st      = st;
      next_st.meta = pin;
      next_st.sync = st.meta;
   end

   // register; multi-bit groups may skew by a cycle, users wait it out
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign synced = st.sync;

endmodule // pin_sync
`default_nettype wire

// ===== rtl/pulse_timer.sv
// loadable down counter that marks the end of a timed interval
`timescale 1ns/10ps
`default_nettype none

module pulse_timer #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // control
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   // status
   output logic              done
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt;    // cycles left
      logic         done;   // one-cycle end mark
   } timer_state_t;

   timer_state_t st;
   timer_state_t next_st;

   // count down, flag the step from one to zero
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.cnt = load;
      end else if (st.cnt != '0) begin
         next_st.cnt  = st.cnt - W'(1);
         next_st.done = (st.cnt == W'(1));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;

endmodule // pulse_timer
`default_nettype wire

// ===== rtl/isa_flash_pointer_port.sv
// isa slave giving pointer-indexed access to bulk flash and a boot window
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - respond only to i/o 0300h to 0307h
// - boot window C8000h-CFFFFh, byte reads, writes ignored
// - 16-bit cycle flagged for 0300h, 0302h, 0304h
// - upper pointer keeps four bits, a20..a17
// - no wait states, cycles never stretched
// - lower pointer write-only, holds a16..a1
// - data port reads/writes flash word at pointer
// - flash only through i/o, 20-bit word pointer
// - no strap, no bulk writes; boot never programmed
module isa_flash_pointer_port (
   // clock and reset
   input  wire logic                                    sys_clk,
   input  wire logic                                    rst_n,
   // isa bus control and address (asynchronous pins)
   input  wire flash_port_pkg::isa_ctl_t                isa_ctl,
   // isa data bus
   input  wire logic [flash_port_pkg::DATA_W-1:0]       sd_in,
   output logic      [flash_port_pkg::DATA_W-1:0]       sd_out,
   output logic                                         sd_oe,
   // isa 16-bit i/o select, open drain
   output logic                                         iocs16_n_out,
   output logic                                         iocs16_oe,
   // bulk flash array
   output flash_port_pkg::flash_ctl_t                   flash_ctl,
   input  wire logic [flash_port_pkg::DATA_W-1:0]       flash_dq_in,
   output logic      [flash_port_pkg::DATA_W-1:0]       flash_dq_out,
   output logic                                         flash_dq_oe,
   // boot firmware store, read only
   output logic      [flash_port_pkg::BOOT_ADDR_W-1:0]  boot_addr,
   output logic                                         boot_oe_n,
   input  wire logic [flash_port_pkg::BOOT_DATA_W-1:0]  boot_data_in,
   // programming voltage strap and switch to the bulk array only
   input  wire logic                                    vpp_strap,
   output logic                                         bulk_vpp_en
);
   import flash_port_pkg::*;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   port_state_t             st;          // all registered state
   port_state_t             next_st;     // its next value
   isa_ctl_t                isa;         // synced bus control
   logic [DATA_W-1:0]       sd_sync;     // synced host data
   logic [DATA_W-1:0]       dq_sync;     // synced flash data
   logic [BOOT_DATA_W-1:0]  boot_sync;   // synced boot data
   logic                    vpp_sync;    // synced strap level
   logic                    tmr_start;   // load the write timer
   logic [TIMER_W-1:0]      tmr_load;    // interval to load
   logic                    tmr_done;    // interval over
   logic                    io_hit;      // address inside our block
   logic                    word_reg;    // one of the three word locations
   logic                    io_rd;       // i/o read on our block
   logic                    io_wr;       // i/o write on our block
   logic                    mem_hit;     // boot window read
   logic                    wr_end;      // write strobe just released
   logic                    port_rd;     // data port read

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   // all pins are asynchronous
   pin_sync #(.W($bits(isa_ctl_t))) u_sync_ctl (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (isa_ctl),
      .synced  (isa)
   );

   pin_sync #(.W(DATA_W)) u_sync_sd (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (sd_in),
      .synced  (sd_sync)
   );

   pin_sync #(.W(DATA_W)) u_sync_dq (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (flash_dq_in),
      .synced  (dq_sync)
   );

   pin_sync #(.W(BOOT_DATA_W)) u_sync_boot (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (boot_data_in),
      .synced  (boot_sync)
   );

   pin_sync #(.W(1)) u_sync_vpp (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin     (vpp_strap),
      .synced  (vpp_sync)
   );

   // -----------------------------------------------------------------
   // flash write strobe timer
   // -----------------------------------------------------------------
   pulse_timer #(.W(TIMER_W)) u_we_timer (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .start   (tmr_start),
      .load    (tmr_load),
      .done    (tmr_done)
   );

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   // dma cycles carry aen high and are never ours on i/o; the boot window read decode ignores aen
   always_comb begin
      io_hit   = !isa.aen
                 && (isa.sa[15:IO_DEC_LSB] == IO_BASE[15:IO_DEC_LSB]);
      // the last word of the block is decoded but is not a 16-bit location
      word_reg = io_hit
                 && (isa.sa[15:IO_REG_LSB] != IO_LAST[15:IO_REG_LSB]);
      io_rd    = io_hit && !isa.ior_n;
      io_wr    = io_hit && !isa.iow_n;
      // only memory reads are decoded, so writes to the window fall away
      mem_hit  = !isa.memr_n
                 && (isa.sa[19:BOOT_ADDR_W] == BOOT_BASE[19:BOOT_ADDR_W]);
      port_rd  = io_rd
                 && (isa.sa[15:IO_REG_LSB] == WORD_PORT_ADDR[15:IO_REG_LSB]);
      wr_end   = st.wr_hit && !st.prev.iow_n && isa.iow_n;
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st      = st;
      tmr_start    = 1'b0;
      tmr_load     = WE_LOW_LOAD;
      next_st.prev = isa;

      // 16-bit select follows the address alone, no strobe needed
      next_st.iocs16_oe  = word_reg;
      next_st.iocs16_out = 1'b0;

      // the strap feeds the bulk array only; no path exists to boot store
      next_st.vpp_en = vpp_sync;

      // track the open write strobe; data is final just before release
      if (io_wr) begin
         next_st.wr_hit = 1'b1;
         next_st.waddr  = isa.sa[15:0];
         next_st.wdata  = sd_sync;
      end else if (wr_end || isa.iow_n) begin
         next_st.wr_hit = 1'b0;
      end

      // commit the write on strobe release; no ready is ever pulled
      if (wr_end) begin
         if (st.waddr[15:IO_REG_LSB] == PTR_LOW_ADDR[15:IO_REG_LSB]) begin
            next_st.ptr_low = st.wdata;
         end else if (st.waddr[15:IO_REG_LSB] == PTR_HIGH_ADDR[15:IO_REG_LSB]) begin
            // upper twelve bits of the word are discarded
            next_st.ptr_high = st.wdata[PTR_HIGH_W-1:0];
         end else if (st.waddr[15:IO_REG_LSB] == WORD_PORT_ADDR[15:IO_REG_LSB]) begin
            // word goes out verbatim, command words included
            if (vpp_sync && (st.phase == W_IDLE)) begin
               next_st.phase  = W_LOW;
               next_st.dq_out = st.wdata;
               tmr_start      = 1'b1;
               tmr_load       = WE_LOW_LOAD;
            end
         end
      end

      // address straight from the pointer
      next_st.flash.addr = {next_st.ptr_high, next_st.ptr_low};

      // write pulse sequencer
      case (st.phase)
         W_IDLE: begin
            // array enabled only for data port reads and for the start of a write pulse
            next_st.dq_oe      = 1'b0;
            next_st.flash.we_n = 1'b1;
            next_st.flash.ce_n = !port_rd;
            next_st.flash.oe_n = !port_rd;
            if (next_st.phase == W_LOW) begin
               next_st.flash.ce_n = 1'b0;
               next_st.flash.oe_n = 1'b1;
               next_st.flash.we_n = 1'b0;
               next_st.dq_oe      = 1'b1;
            end
         end
         W_LOW: begin
            // write enable low for the timed interval
            if (tmr_done) begin
               next_st.phase      = W_HOLD;
               next_st.flash.we_n = 1'b1;
               tmr_start          = 1'b1;
               tmr_load           = WE_HOLD_LOAD;
            end
         end
         W_HOLD: begin
            // data held past the rising edge, then bus released
            if (tmr_done) begin
               next_st.phase      = W_IDLE;
               next_st.dq_oe      = 1'b0;
               next_st.flash.ce_n = 1'b1;
            end
         end
         default: begin
            next_st.phase = W_IDLE;
         end
      endcase

      // read data path, live while the strobe is low
      next_st.sd_oe  = io_rd || mem_hit;
      next_st.sd_out = READ_FILL;
      if (mem_hit) begin
         // byte-wide window
         next_st.sd_out = {BOOT_HI_FILL, boot_sync};
      end else if (port_rd) begin
         next_st.sd_out = dq_sync;
      end

      // boot store addressing, enabled only on a window read
      next_st.boot_addr = isa.sa[BOOT_ADDR_W-1:0];
      next_st.boot_oe_n = !mem_hit;
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // flash strobes idle high and the pointer clears at reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st                <= '0;
         st.prev.ior_n     <= 1'b1;
         st.prev.iow_n     <= 1'b1;
         st.prev.memr_n    <= 1'b1;
         st.ptr_low        <= PTR_LOW_RST;
         st.ptr_high       <= PTR_HIGH_RST;
         st.phase          <= W_IDLE;
         st.flash.ce_n     <= 1'b1;
         st.flash.oe_n     <= 1'b1;
         st.flash.we_n     <= 1'b1;
         st.boot_oe_n      <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from the state register
   // -----------------------------------------------------------------
   assign sd_out       = st.sd_out;
   assign sd_oe        = st.sd_oe;
   assign iocs16_n_out = st.iocs16_out;
   assign iocs16_oe    = st.iocs16_oe;
   assign flash_ctl    = st.flash;
   assign flash_dq_out = st.dq_out;
   assign flash_dq_oe  = st.dq_oe;
   assign boot_addr    = st.boot_addr;
   assign boot_oe_n    = st.boot_oe_n;
   assign bulk_vpp_en  = st.vpp_en;

endmodule // isa_flash_pointer_port
`default_nettype wire

// ===== verif/isa_flash_pointer_port_chk.sv
// assertion checker for the isa flash pointer port, bound to its ports
`timescale 1ns/10ps
`default_nettype none

module isa_flash_pointer_port_chk
   import flash_port_pkg::*;
(
   // clock and reset
   input wire logic                                   sys_clk,
   input wire logic                                   rst_n,
   // watched ports
   input wire flash_port_pkg::isa_ctl_t               isa_ctl,
   input wire logic                                   sd_oe,
   input wire logic                                   iocs16_oe,
   input wire flash_port_pkg::flash_ctl_t             flash_ctl,
   input wire logic [flash_port_pkg::DATA_W-1:0]      flash_dq_out,
   input wire logic [flash_port_pkg::BOOT_ADDR_W-1:0] boot_addr,
   input wire logic                                   boot_oe_n,
   input wire logic                                   vpp_strap,
   input wire logic                                   bulk_vpp_en
);
   // -----------------------------------------------------------------
   // request history, five samples deep to cover sync and register delay
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] ior;   // block reads
      logic [4:0] mem;   // window reads
      logic [4:0] d16;   // word addresses
      logic [4:0] wr;    // pointer writes
   } hist_t;
   hist_t hist;          // registered
   hist_t next_hist;     // next
   logic  io_hit;        // no dma
   logic  rd_io;
   logic  rd_mem;
   logic  d16;
   logic  wr_ptr;

   assign io_hit = !isa_ctl.aen && isa_ctl.sa[15:3] == 13'h060;
   assign rd_io  = io_hit && !isa_ctl.ior_n;
   assign rd_mem = !isa_ctl.memr_n && isa_ctl.sa[19:15] == 5'h19;
   assign d16    = io_hit && isa_ctl.sa[2:1] != 2'h3;
   assign wr_ptr = io_hit && !isa_ctl.iow_n && !isa_ctl.sa[2];

   // shift each request flag into its history
   always_comb begin
      next_hist.ior = {hist.ior[3:0], rd_io};
      next_hist.mem = {hist.mem[3:0], rd_mem};
      next_hist.d16 = {hist.d16[3:0], d16};
      next_hist.wr  = {hist.wr[3:0], wr_ptr};
   end

   // history register, cleared so no stale request survives a reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= '0;
      end else begin
         hist <= next_hist;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   AST_IO_NO_WAIT: assert property (rd_io && &hist.ior[3:0] |-> sd_oe)
      else $error("read not answered");
   AST_IO_DECODE: assert property (sd_oe |-> |hist.ior || |hist.mem)
      else $error("stray data drive");
   AST_WORD_FLAG: assert property (iocs16_oe |-> |hist.d16)
      else $error("stray 16-bit flag");
   AST_WORD_FLAG_SET: assert property (d16 && &hist.d16[3:0] |-> iocs16_oe)
      else $error("16-bit flag missing");
   AST_BOOT_DECODE: assert property (!boot_oe_n |-> |hist.mem)
      else $error("stray boot enable");
   AST_BOOT_ADDR: assert property (rd_mem && &hist.mem[3:0]
      && isa_ctl.sa == $past(isa_ctl.sa, 4) |-> !boot_oe_n && boot_addr == isa_ctl.sa[14:0])
      else $error("boot address wrong");
   AST_WE_STRAP: assert property (!flash_ctl.we_n |-> bulk_vpp_en)
      else $error("write without strap");
   AST_STRAP_OFF: assert property ((!vpp_strap)[*4] |-> !bulk_vpp_en)
      else $error("voltage without strap");
   AST_WE_PULSE: assert property ($fell(flash_ctl.we_n) |=>
      (!flash_ctl.we_n && $stable(flash_dq_out) && $stable(flash_ctl.addr))[*8])
      else $error("write pulse broken");
   AST_PTR_HOLD: assert property ($changed(flash_ctl.addr) |-> |hist.wr)
      else $error("pointer moved alone");
endmodule // isa_flash_pointer_port_chk

bind isa_flash_pointer_port isa_flash_pointer_port_chk u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .isa_ctl(isa_ctl), .sd_oe(sd_oe),
   .iocs16_oe(iocs16_oe), .flash_ctl(flash_ctl), .flash_dq_out(flash_dq_out),
   .boot_addr(boot_addr), .boot_oe_n(boot_oe_n), .vpp_strap(vpp_strap),
   .bulk_vpp_en(bulk_vpp_en)
);

`default_nettype wire

// ===== verif/flash_array_model.sv
// behavioural bulk flash array sitting on the port's flash pins
`timescale 1ns/10ps
`default_nettype none

module flash_array_model
   import flash_port_pkg::*;
(
   // clock
   input  wire logic                              sys_clk,
   // pins driven by the port
   input  wire flash_port_pkg::flash_ctl_t        flash_ctl,
   input  wire logic [flash_port_pkg::DATA_W-1:0] dq_out,
   input  wire logic                              dq_oe,
   // resolved level on the data pins
   output logic      [flash_port_pkg::DATA_W-1:0] dq_in
);
   logic [DATA_W-1:0] mem [logic [FLASH_ADDR_W-1:0]];  // sparse word store
   logic [DATA_W-1:0] last;  // last pin level

   // words and command words alike are kept raw, latched on we rising
   always @(posedge flash_ctl.we_n) begin
      if (flash_ctl.ce_n === 1'b0 && dq_oe === 1'b1) begin
         mem[flash_ctl.addr] = dq_out;
      end
   end

   // port drive, array output, or a toggling released bus
   always_comb begin
      if (dq_oe) begin
         dq_in = dq_out;
      end else if (!flash_ctl.ce_n && !flash_ctl.oe_n) begin
         dq_in = mem.exists(flash_ctl.addr) ? mem[flash_ctl.addr] : 16'hFFFF;
      end else begin
         dq_in = ~last;  // no stale word can pass for a read
      end
   end

   // remember the level so a released bus toggles every cycle
   always @(posedge sys_clk) begin
      last <= dq_in;
   end
endmodule // flash_array_model

`default_nettype wire

// ===== verif/isa_flash_pointer_port_tb.sv
// self-checking bench for the isa flash pointer port
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module isa_flash_pointer_port_tb;
   import flash_port_pkg::*;

   localparam int LIMIT = 4000;  // about five times the planned run
   logic                   sys_clk;
   logic                   rst_n;
   isa_ctl_t               ctl;  // bus strobes and address
   logic [DATA_W-1:0]      sd_drv;  // bench drive on the data bus
   logic [DATA_W-1:0]      sd_bus;
   logic [DATA_W-1:0]      sd_out;
   logic                   sd_oe;
   logic                   iocs16_oe;
   logic                   iocs16_n;
   flash_ctl_t             flash_ctl;
   logic [DATA_W-1:0]      dq_in;
   logic [DATA_W-1:0]      dq_out;
   logic                   dq_oe;
   logic [BOOT_ADDR_W-1:0] boot_addr;
   logic                   boot_oe_n;
   logic [BOOT_DATA_W-1:0] boot_data;
   logic                   vpp_strap;
   logic                   bulk_vpp_en;
   logic [16:0]            r;  // {drive enable, data} of a read
   int                     miscompares;
   int                     tests_run;
   int                     cycles;
   logic [15:0]            io_out [3] = '{16'h02FE, 16'h0308, 16'h0320};
   logic [19:0]            boot_in [3] = '{20'hC8000, 20'hCFFFF, 20'hC9A34};
   logic [19:0]            boot_out [2] = '{20'hC7FFF, 20'hD0000};

   // resolved bus; boot byte is a pattern of its address
   assign sd_bus    = sd_oe ? sd_out : sd_drv;
   assign boot_data = boot_oe_n ? ~boot_addr[7:0] : boot_addr[7:0] ^ 8'h5A;

   always #2.5 sys_clk = ~sys_clk;

   isa_flash_pointer_port u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .isa_ctl(ctl), .sd_in(sd_bus),
      .sd_out(sd_out), .sd_oe(sd_oe), .iocs16_n_out(iocs16_n), .iocs16_oe(iocs16_oe),
      .flash_ctl(flash_ctl), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .boot_addr(boot_addr), .boot_oe_n(boot_oe_n),
      .boot_data_in(boot_data), .vpp_strap(vpp_strap), .bulk_vpp_en(bulk_vpp_en)
   );

   flash_array_model u_flash (
      .sys_clk(sys_clk), .flash_ctl(flash_ctl), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in)
   );

   // -----------------------------------------------------------------
   // bus tasks, all changes at the falling edge
   // -----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // write: spacing after it covers the whole flash write pulse
   task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
      ctl.sa = {4'h0, a};
      ctl.aen = 1'b0;
      sd_drv = d;
      cyc(5);
      ctl.iow_n = 1'b0;
      cyc(4);
      ctl.iow_n = 1'b1;
      cyc(4);
      ctl.aen = 1'b1;
      sd_drv = ~d;
      cyc(40);
   endtask

   // read: the flag is checked once the address has settled
   task automatic io_rd(input logic [15:0] a, output logic [16:0] q);
      ctl.sa = {4'h0, a};
      ctl.aen = 1'b0;
      cyc(5);
      `CHK({iocs16_oe, iocs16_n}, {a[15:3] == 13'h060 && a[2:1] != 2'h3, 1'b0})
      ctl.ior_n = 1'b0;
      cyc(7);
      q = {sd_oe, sd_out};
      ctl.ior_n = 1'b1;
      cyc(5);
      ctl.aen = 1'b1;
      cyc(1);
   endtask

   task automatic mem_rd(input logic [19:0] a, output logic [16:0] q);
      ctl.sa = a;
      cyc(2);
      ctl.memr_n = 1'b0;
      cyc(8);
      q = {sd_oe, sd_out};
      ctl.memr_n = 1'b1;
      cyc(5);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      ctl = '{sa: '0, default: 1'b1};
      sd_drv = 16'h0000;
      vpp_strap = 1'b1;
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      cyc(10);
      `CHK({sd_oe, flash_ctl.we_n, dq_oe, boot_oe_n, bulk_vpp_en}, 5'h0A)
      rst_n = 1'b1;
      cyc(6);
      `CHK(bulk_vpp_en, 1'b1)
      io_wr(16'h0300, 16'hA5C3);
      io_wr(16'h0302, 16'hFFF9);
      `CHK(flash_ctl.addr, 20'h9A5C3)
      io_wr(16'h0304, 16'h1234);
      `CHK(u_flash.mem[20'h9A5C3], 16'h1234)
      io_rd(16'h0304, r);
      `CHK(r, 17'h11234)
      `CHK(flash_ctl.addr, 20'h9A5C3)
      io_rd(16'h0300, r);
      `CHK(r, 17'h10000)
      io_rd(16'h0306, r);
      `CHK(r, 17'h10000)
      foreach (io_out[i]) begin
         io_wr(io_out[i], 16'h0000);
         io_rd(io_out[i], r);
         `CHK(r[16], 1'b0)
      end
      `CHK(flash_ctl.addr, 20'h9A5C3)
      io_wr(16'h0300, 16'hFFFF);
      io_wr(16'h0302, 16'h000F);
      io_wr(16'h0304, 16'hBEEF);
      io_rd(16'h0304, r);
      `CHK(r, 17'h1BEEF)
      vpp_strap = 1'b0;
      cyc(6);
      `CHK(bulk_vpp_en, 1'b0)
      io_wr(16'h0304, 16'h5555);
      io_rd(16'h0304, r);
      `CHK(r, 17'h1BEEF)
      foreach (boot_in[i]) begin
         mem_rd(boot_in[i], r);
         `CHK(r, {1'b1, 8'h00, boot_in[i][7:0] ^ 8'h5A})
      end
      foreach (boot_out[i]) begin
         mem_rd(boot_out[i], r);
         `CHK(r[16], 1'b0)
      end
      end_of_test();
   end
endmodule // isa_flash_pointer_port_tb

`default_nettype wire
